// ===== hdl/aqs_params.svh
`ifndef AQS_PARAMS_SVH
`define AQS_PARAMS_SVH

// ==========================================================
// register map (byte addresses)
`define AQS_OFF_Q1CTRL   12'h000
`define AQS_OFF_Q2CTRL   12'h004
`define AQS_OFF_STATUS   12'h008
`define AQS_OFF_FLAGS    12'h00c
`define AQS_PAGE_CCW     4'h2
`define AQS_PAGE_RES     4'h3

// ==========================================================
// control fields
`define AQS_BIT_EN       0
`define AQS_BIT_CONT     1
`define AQS_BIT_SWTRIG   2
`define AQS_BIT_RESUME   3
`define AQS_Q2BEG_LSB    8
`define AQS_Q2BEG_MSB    14
`define AQS_Q2BEG_RST    7'h40

// ==========================================================
// command word fields
`define AQS_CW_CH_MSB    5
`define AQS_CW_IST_LSB   6
`define AQS_CW_IST_MSB   7
`define AQS_CW_BYP       8
`define AQS_CW_PAUSE     9

// ==========================================================
// channel codes
`define AQS_CH_EOQ       6'h3f
`define AQS_CH_REF_HIGH  6'h3c
`define AQS_CH_REF_LOW   6'h3d
`define AQS_CH_REF_MID   6'h3e
`define AQS_SEL_REF_HIGH 5'h10
`define AQS_SEL_REF_LOW  5'h11
`define AQS_SEL_REF_MID  5'h12
`define AQS_SEL_NONE     5'h1f

// ==========================================================
// phase lengths in conversion clocks, SAR start code, table end
`define AQS_INIT_CYC     5'h02
`define AQS_FINAL_BASE   5'h02
`define AQS_RES_CYC      5'h0a
`define AQS_SAR_START    10'h200
`define AQS_TABLE_END    7'h40

`endif

// ===== hdl/aqs_pkg.sv
package aqs_pkg;

    typedef enum logic [5:0] {
        ST_IDLE  = 6'b000001,
        ST_FETCH = 6'b000010,
        ST_INIT  = 6'b000100,
        ST_FINAL = 6'b001000,
        ST_RES   = 6'b010000,
        ST_STORE = 6'b100000
    } aqs_seq_t;

    typedef enum logic [4:0] {
        Q_IDLE   = 5'b00001,
        Q_ACTIVE = 5'b00010,
        Q_PAUSED = 5'b00100,
        Q_SUSP   = 5'b01000,
        Q_PEND   = 5'b10000
    } aqs_qstate_t;

endpackage : aqs_pkg

// ===== hdl/aqs_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "aqs_params.svh"

// Contract
// RULE1 - non-bypassed conversion samples through the buffer for exactly two conversion clocks
// RULE2 - final sample lasts 2, 4, 8 or 16 clocks per sample_time_select
// RULE3 - resolution phase lasts ten conversion clocks, filling the approximation register
// RULE4 - amp_bypass_bit set skips the buffered initial sample phase
// RULE5 - software gives bypassed words a final sample of at least four clocks
// RULE6 - software should avoid two-clock sample in bypass at high clock rates
// RULE7 - selector picks one of 16 pins or reference high, low, mid
// RULE8 - result resolved MSB first, ten bits stored at the word's result slot
// RULE9 - 64-entry command table holds one or two queues
// RULE10 - a triggered queue converts its words in order, storing each result
// RULE11 - with no queue active, a trigger starts that queue at once
// RULE12 - queue 2 trigger during queue 1 activity waits as trigger pending
// RULE13 - further queue 2 triggers while pending count as overrun
// RULE14 - queue 1 trigger aborts active queue 2 and marks it suspended
// RULE15 - queue 2 triggers while suspended count as overrun
// RULE16 - suspended queue 2 resumes after queue 1; resume bit picks start word
// RULE17 - simultaneous triggers start queue 1, queue 2 becomes trigger pending
// RULE18 - after a pause word converts, queue pauses, flags it, awaits trigger
// RULE19 - queue mode governs all its subqueues; scan mode applies to whole queue
// RULE20 - after pause continue with next word; no subqueue repeats mid-queue
// RULE21 - triggers during subqueue execution are ignored but set overrun
// RULE22 - continuous scan: trigger after completion restarts at first word
// RULE23 - channel 63 ends the queue: completion flag, idle, no conversion
// RULE24 - end of queue beats pause on the same word: no pause flag
// RULE25 - status shows idle, active, paused, suspended or pending per queue
module aqs_top
    import aqs_pkg::*;
#(
    parameter int PRESCALE = 25
)(
    // clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // external trigger pins
    input  wire logic        trig1_i,
    input  wire logic        trig2_i,
    // analog front end
    input  wire logic        cmp_i,
    output logic      [4:0]  mux_sel_o,
    output logic             amp_buf_o,
    output logic             sample_o,
    output logic      [9:0]  dac_code_o
);

    initial
    begin
        if (PRESCALE < 3 || PRESCALE > 256)
            $error("aqs_top: PRESCALE must be 3..256");
    end

    // ==========================================================
    // storage and registers
    logic [9:0]  ccw_mem [64];
    logic [9:0]  res_mem [64];
    logic        q1_en;
    logic        q1_cont;
    logic        q2_en;
    logic        q2_cont;
    logic        q2_resume;
    logic [6:0]  q2_begin;
    logic [5:0]  flags;
    aqs_qstate_t q1_state;
    aqs_qstate_t q2_state;
    logic [6:0]  q1_ptr;
    logic [6:0]  q2_ptr;
    logic [6:0]  q2_sub;
    aqs_seq_t    seq_state;
    logic        seq_q;
    logic [9:0]  word;
    logic [4:0]  cnt;
    logic [3:0]  bit_idx;

    // ==========================================================
    // apb decode
    logic        acc;
    logic        wr;
    logic [5:0]  widx;
    logic        is_ccw;
    logic        is_res;
    logic        sw1;
    logic        sw2;

    assign acc    = psel_i & penable_i & ~pready_o;
    assign wr     = acc & pwrite_i;
    assign widx   = paddr_i[7:2];
    assign is_ccw = paddr_i[11:8] == `AQS_PAGE_CCW;
    assign is_res = paddr_i[11:8] == `AQS_PAGE_RES;
    assign sw1    = wr & (paddr_i == `AQS_OFF_Q1CTRL) & pwdata_i[`AQS_BIT_SWTRIG];
    assign sw2    = wr & (paddr_i == `AQS_OFF_Q2CTRL) & pwdata_i[`AQS_BIT_SWTRIG];

    // ==========================================================
    // conversion clock enable
    logic [7:0] div_cnt;
    logic       conv_tick;

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            div_cnt   <= 8'h00;
            conv_tick <= 1'b0;
        end
        else if (div_cnt == 8'(PRESCALE - 1))
        begin
            div_cnt   <= 8'h00;
            conv_tick <= 1'b1;
        end
        else
        begin
            div_cnt   <= div_cnt + 8'h01;
            conv_tick <= 1'b0;
        end
    end

    // ==========================================================
    // pin synchronisers
    logic [2:0] t1_sync;
    logic [2:0] t2_sync;
    logic [1:0] cmp_sync;

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            t1_sync  <= 3'h0;
            t2_sync  <= 3'h0;
            cmp_sync <= 2'h0;
        end
        else
        begin
            t1_sync  <= {t1_sync[1:0], trig1_i};
            t2_sync  <= {t2_sync[1:0], trig2_i};
            cmp_sync <= {cmp_sync[0], cmp_i};
        end
    end

    // ==========================================================
    // trigger arbitration
    logic t1;
    logic t2;
    logic t1_take;
    logic preempt;
    logic abort2;
    logic q1_busy_next;
    logic [6:0] cur_ptr;
    logic [9:0] cur_word;
    logic end_of_queue_code;
    logic ev_store;
    logic ev_done;
    logic ev_pause;
    logic c1;
    logic c2;
    logic p1;
    logic p2;
    logic s1;
    logic s2;

    // disabled queues never see a trigger
    assign t1      = q1_en & ((t1_sync[1] & ~t1_sync[2]) | sw1); // RULE19
    assign t2      = q2_en & ((t2_sync[1] & ~t2_sync[2]) | sw2); // RULE19
    assign t1_take = t1 & (q1_state == Q_IDLE || q1_state == Q_PAUSED);
    assign preempt = t1_take & (q2_state == Q_ACTIVE); // RULE14
    assign abort2  = preempt & seq_q;

    assign cur_ptr  = seq_q ? q2_ptr : q1_ptr;
    assign cur_word = ccw_mem[cur_ptr[5:0]];
    // table end and queue 2 start both close queue 1
    assign end_of_queue_code = (cur_word[`AQS_CW_CH_MSB:0] == `AQS_CH_EOQ) // RULE23
               | (cur_ptr >= `AQS_TABLE_END)
               | (~seq_q & (cur_ptr == q2_begin));

    assign ev_done  = (seq_state == ST_FETCH) & end_of_queue_code & ~abort2;
    assign ev_store = (seq_state == ST_STORE) & ~abort2;
    assign ev_pause = ev_store & word[`AQS_CW_PAUSE];
    assign c1 = ev_done & ~seq_q;
    assign c2 = ev_done & seq_q;
    assign p1 = ev_pause & ~seq_q;
    assign p2 = ev_pause & seq_q;
    assign s1 = ev_store & ~seq_q;
    assign s2 = ev_store & seq_q;

    assign q1_busy_next = ((q1_state == Q_ACTIVE) & ~c1 & ~p1) | t1_take;

    // ==========================================================
    // queue 1 state
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            q1_state <= Q_IDLE;
            q1_ptr   <= 7'h00;
        end
        else
        begin
            if (c1)
                q1_state <= Q_IDLE; // RULE23
            else if (p1)
                q1_state <= Q_PAUSED; // RULE18
            else if (t1_take)
                q1_state <= Q_ACTIVE; // RULE11
            if (t1_take && q1_state == Q_IDLE)
                q1_ptr <= 7'h00; // RULE22
            else if (s1)
                q1_ptr <= q1_ptr + 7'h01; // RULE20
        end
    end

    // ==========================================================
    // queue 2 state
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            q2_state <= Q_IDLE;
            q2_ptr   <= `AQS_Q2BEG_RST;
            q2_sub   <= `AQS_Q2BEG_RST;
        end
        else
        begin
            case (q2_state)
                Q_IDLE, Q_PAUSED:
                begin
                    if (t2)
                    begin
                        // a same-cycle queue 1 trigger also lands here
                        q2_state <= q1_busy_next ? Q_PEND : Q_ACTIVE; // RULE12 RULE17
                        if (q2_state == Q_IDLE)
                        begin
                            q2_ptr <= q2_begin; // RULE22
                            q2_sub <= q2_begin;
                        end
                    end
                end
                Q_ACTIVE:
                begin
                    if (preempt)
                        q2_state <= Q_SUSP; // RULE14
                    else if (c2)
                        q2_state <= Q_IDLE; // RULE23
                    else if (p2)
                        q2_state <= Q_PAUSED; // RULE18
                    if (s2)
                    begin
                        q2_ptr <= q2_ptr + 7'h01;
                        if (word[`AQS_CW_PAUSE])
                            q2_sub <= q2_ptr + 7'h01;
                    end
                end
                Q_SUSP, Q_PEND:
                begin
                    if (!q1_busy_next)
                    begin
                        q2_state <= Q_ACTIVE; // RULE16
                        if (q2_state == Q_SUSP && !q2_resume)
                            q2_ptr <= q2_sub; // RULE16
                    end
                end
                default:
                    q2_state <= Q_IDLE;
            endcase
        end
    end

    // ==========================================================
    // conversion sequencer
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            seq_state  <= ST_IDLE;
            seq_q      <= 1'b0;
            word       <= 10'h000;
            cnt        <= 5'h00;
            bit_idx    <= 4'h0;
            dac_code_o <= 10'h000;
            mux_sel_o  <= `AQS_SEL_NONE;
        end
        else if (abort2 && seq_state != ST_IDLE)
            seq_state <= ST_IDLE; // RULE14
        else
        begin
            case (seq_state)
                ST_IDLE:
                begin
                    // queue 1 always wins the converter
                    if (q1_state == Q_ACTIVE)
                    begin
                        seq_q     <= 1'b0;
                        seq_state <= ST_FETCH;
                    end
                    else if (q2_state == Q_ACTIVE)
                    begin
                        seq_q     <= 1'b1;
                        seq_state <= ST_FETCH;
                    end
                end
                ST_FETCH:
                begin
                    // end of queue wins over a pause on the same word
                    if (end_of_queue_code)
                        seq_state <= ST_IDLE; // RULE24
                    else if (conv_tick)
                    begin
                        // start on a tick so each phase is whole clocks
                        word <= cur_word;
                        cnt  <= 5'h00;
                        seq_state <= cur_word[`AQS_CW_BYP] ? ST_FINAL : ST_INIT; // RULE4
                        case (cur_word[`AQS_CW_CH_MSB:0]) // RULE7
                            `AQS_CH_REF_HIGH: mux_sel_o <= `AQS_SEL_REF_HIGH;
                            `AQS_CH_REF_LOW:  mux_sel_o <= `AQS_SEL_REF_LOW;
                            `AQS_CH_REF_MID:  mux_sel_o <= `AQS_SEL_REF_MID;
                            default:
                                mux_sel_o <= cur_word[`AQS_CW_CH_MSB:4] == 2'h0
                                           ? {1'b0, cur_word[3:0]} : `AQS_SEL_NONE;
                        endcase
                    end
                end
                ST_INIT:
                begin
                    if (conv_tick)
                    begin
                        if (cnt == `AQS_INIT_CYC - 5'h01)
                        begin
                            cnt       <= 5'h00;
                            seq_state <= ST_FINAL; // RULE1
                        end
                        else
                            cnt <= cnt + 5'h01;
                    end
                end
                ST_FINAL:
                begin
                    if (conv_tick)
                    begin
                        if (cnt == (`AQS_FINAL_BASE << word[`AQS_CW_IST_MSB:`AQS_CW_IST_LSB])
                                   - 5'h01)
                        begin
                            cnt        <= 5'h00;
                            bit_idx    <= 4'h9;
                            dac_code_o <= `AQS_SAR_START;
                            seq_state  <= ST_RES; // RULE2
                        end
                        else
                            cnt <= cnt + 5'h01;
                    end
                end
                ST_RES:
                begin
                    if (conv_tick)
                    begin
                        // comparator high keeps the trial bit
                        dac_code_o[bit_idx] <= cmp_sync[1]; // RULE8
                        if (bit_idx != 4'h0)
                            dac_code_o[bit_idx - 4'h1] <= 1'b1;
                        bit_idx <= bit_idx - 4'h1;
                        if (cnt == `AQS_RES_CYC - 5'h01)
                            seq_state <= ST_STORE; // RULE3
                        else
                            cnt <= cnt + 5'h01;
                    end
                end
                ST_STORE:
                    seq_state <= ST_IDLE; // RULE10
                default:
                    seq_state <= ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // analog phase strobes, one core cycle behind the state
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            amp_buf_o <= 1'b0;
            sample_o  <= 1'b0;
        end
        else
        begin
            amp_buf_o <= seq_state == ST_INIT;
            sample_o  <= (seq_state == ST_INIT) | (seq_state == ST_FINAL);
        end
    end

    // ==========================================================
    // tables
    always_ff @(posedge core_clk_i)
    begin
        if (wr && is_ccw)
            ccw_mem[widx] <= pwdata_i[9:0]; // RULE9
        if (ev_store)
            res_mem[cur_ptr[5:0]] <= dac_code_o; // RULE8
    end

    // ==========================================================
    // control registers and sticky flags
    logic [5:0] flag_set;

    assign flag_set = {t2 & (q2_state == Q_ACTIVE || q2_state == Q_SUSP
                             || q2_state == Q_PEND), // RULE13 RULE15 RULE21
                       p2, c2,
                       t1 & (q1_state == Q_ACTIVE), // RULE21
                       p1, c1}; // RULE18

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            q1_en     <= 1'b0;
            q1_cont   <= 1'b0;
            q2_en     <= 1'b0;
            q2_cont   <= 1'b0;
            q2_resume <= 1'b0;
            q2_begin  <= `AQS_Q2BEG_RST;
            flags     <= 6'h00;
        end
        else
        begin
            // single scan drops its enable when the queue ends
            if (c1 && !q1_cont)
                q1_en <= 1'b0; // RULE19
            if (c2 && !q2_cont)
                q2_en <= 1'b0; // RULE19
            if (wr && paddr_i == `AQS_OFF_Q1CTRL)
            begin
                q1_en   <= pwdata_i[`AQS_BIT_EN];
                q1_cont <= pwdata_i[`AQS_BIT_CONT];
            end
            if (wr && paddr_i == `AQS_OFF_Q2CTRL)
            begin
                q2_en     <= pwdata_i[`AQS_BIT_EN];
                q2_cont   <= pwdata_i[`AQS_BIT_CONT];
                q2_resume <= pwdata_i[`AQS_BIT_RESUME];
                q2_begin  <= pwdata_i[`AQS_Q2BEG_MSB:`AQS_Q2BEG_LSB];
            end
            // set beats the write-one clear
            if (wr && paddr_i == `AQS_OFF_FLAGS)
                flags <= (flags & ~pwdata_i[5:0]) | flag_set;
            else
                flags <= flags | flag_set;
        end
    end

    // ==========================================================
    // apb answer, one wait state on every access
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end
        else
        begin
            pready_o  <= acc;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
            if (acc && !pwrite_i)
            begin
                if (is_ccw)
                    prdata_o <= {22'h000000, ccw_mem[widx]};
                else if (is_res)
                    prdata_o <= {22'h000000, res_mem[widx]};
                else
                    case (paddr_i)
                        `AQS_OFF_Q1CTRL:
                            prdata_o <= {30'h0, q1_cont, q1_en};
                        `AQS_OFF_Q2CTRL:
                            prdata_o <= {17'h0, q2_begin, 4'h0, q2_resume, 1'b0,
                                         q2_cont, q2_en};
                        `AQS_OFF_STATUS:
                            prdata_o <= {7'h0, ~seq_state[0], 1'b0, cur_ptr,
                                         3'h0, q2_state, 3'h0, q1_state}; // RULE25
                        `AQS_OFF_FLAGS:
                            prdata_o <= {26'h0, flags};
                        default:
                            pslverr_o <= 1'b1;
                    endcase
            end
            else if (acc && !(is_ccw || paddr_i == `AQS_OFF_Q1CTRL
                              || paddr_i == `AQS_OFF_Q2CTRL || paddr_i == `AQS_OFF_FLAGS))
                pslverr_o <= 1'b1;
        end
    end

endmodule : aqs_top

`default_nettype wire

// ===== tb/aqs_front_model.sv
`timescale 1ns/1ps
`default_nettype none
module aqs_front_model (
    // converter side
    input  wire logic       clk_i,
    input  wire logic [4:0] sel_i,
    input  wire logic [9:0] dac_i,
    // comparator
    output logic            cmp_o
);
    logic       flip = 1'b0;
    logic [9:0] lvl;
    // ==========
    // pins step by 0x40; references at rails and mid
    assign lvl = sel_i[4] ? {~sel_i[0], {9{sel_i[1:0] == 2'b00}}} : {sel_i[3:0], 6'h15};
    always @(posedge clk_i)
        flip <= ~flip;
    // nothing selected: output wanders, never a stale level
    assign cmp_o = (sel_i == 5'h1f) ? flip : (lvl >= dac_i);
endmodule : aqs_front_model
`default_nettype wire

// ===== tb/aqs_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module aqs_checker #(
    parameter int PRESCALE = 25
)(
    // clock and reset
    input wire logic        core_clk_i,
    input wire logic        rst_n_i,
    // register bus
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    // front end
    input wire logic [4:0]  mux_sel_o,
    input wire logic        amp_buf_o,
    input wire logic        sample_o
);
    logic [19:0] buf_cnt;
    logic [19:0] fin_cnt;
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    // ==========
    // phase lengths in core cycles
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            buf_cnt <= 20'h0;
            fin_cnt <= 20'h0;
        end
        else
        begin
            buf_cnt <= amp_buf_o ? buf_cnt + 20'h1 : 20'h0;
            fin_cnt <= (sample_o && !amp_buf_o) ? fin_cnt + 20'h1 : 20'h0;
        end
    end
    // ==========
    // properties
    AST_INIT_LEN: assert property ($fell(amp_buf_o) |-> buf_cnt == 20'(2 * PRESCALE))
        else $error("buffered sample length wrong");
    AST_FINAL_LEN: assert property ($fell(sample_o) |-> fin_cnt inside
        {20'(2 * PRESCALE), 20'(4 * PRESCALE), 20'(8 * PRESCALE), 20'(16 * PRESCALE)})
        else $error("final sample length wrong");
    AST_BUF_START: assert property ($rose(amp_buf_o) |-> $rose(sample_o))
        else $error("buffered phase not at sample start");
    AST_BUF_IN_SMP: assert property (amp_buf_o |-> sample_o)
        else $error("buffer without sampling");
    AST_MUX_OK: assert property (sample_o |-> mux_sel_o <= 5'h12)
        else $error("bad input selected");
    AST_MUX_HOLD: assert property (sample_o && $past(sample_o) |-> $stable(mux_sel_o))
        else $error("input changed while sampling");
    AST_RDY: assert property (psel_i && penable_i && !pready_o |=> pready_o)
        else $error("no ready");
    AST_RDY_ONLY: assert property (!(psel_i && penable_i) |=> !pready_o)
        else $error("ready without access");
    AST_RDY_PULSE: assert property (pready_o |=> !pready_o)
        else $error("ready too long");
    AST_QUIET: assert property (!pready_o |-> prdata_o == 32'h0 && !pslverr_o)
        else $error("bus outputs not quiet");
endmodule : aqs_checker
bind aqs_top aqs_checker #(.PRESCALE(PRESCALE)) u_chk (.core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .mux_sel_o(mux_sel_o),
    .amp_buf_o(amp_buf_o), .sample_o(sample_o));
`default_nettype wire

// ===== tb/tb_adc_queue_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "aqs_params.svh"
module tb_adc_queue_sequencer;
    logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic        t1 = 1'b0, t2 = 1'b0, smp_q = 1'b0, pready, pslverr, erv, cmp, sample;
    logic [11:0] addr = 12'h0;
    logic [31:0] wd = 32'h0, rdv, prdata;
    logic [4:0]  sel;
    logic [9:0]  dac;
    int          convs = 0, base, err_total = 0, comparisons = 0;
    // word 1 is bypassed with a four-cycle final sample
    logic [9:0]  cw [7] = '{10'h003, 10'h17c, 10'h2c5, 10'h07d, 10'h03f, 10'h0be, 10'h23f};
    logic [9:0]  ex [6] = '{10'h0d5, 10'h3ff, 10'h155, 10'h000, 10'h000, 10'h200};
    always #10 clk = ~clk;
    always @(posedge clk)
    begin
        smp_q <= sample;
        convs <= convs + int'(sample && !smp_q);
    end
    aqs_top #(.PRESCALE(3)) dut (.core_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(addr), .pwdata_i(wd), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .trig1_i(t1), .trig2_i(t2), .cmp_i(cmp),
        .mux_sel_o(sel), .amp_buf_o(), .sample_o(sample), .dac_code_o(dac));
    aqs_front_model u_front (.clk_i(clk), .sel_i(sel), .dac_i(dac), .cmp_o(cmp));
    // ==========
    // bus and check tasks
    task automatic stop_test();
        if (err_total == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] s, e);
        comparisons++;
        if (s !== e)
        begin
            err_total++;
            $display("ERROR %0t %h %h", $time, s, e);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwr <= w;
        addr <= a;
        wd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rdv = prdata;
        erv = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
        if (n >= 20)
        begin
            err_total++;
            stop_test();
        end
    endtask : xfer
    task automatic rc(input logic [11:0] a, input logic [31:0] m, e);
        xfer(1'b0, a, 32'h0);
        chk(rdv & m, e);
    endtask : rc
    // polls a register until the masked value appears, bounded
    task automatic wt(input logic [11:0] a, input logic [31:0] m, e);
        int n;
        n = 0;
        do
        begin
            xfer(1'b0, a, 32'h0);
            n++;
        end
        while ((rdv & m) !== e && n < 300);
        chk(rdv & m, e);
        if ((rdv & m) !== e)
            stop_test();
    endtask : wt
    // pins pass a two-stage synchroniser, so hold each level four cycles
    task automatic pulse(input logic a, b);
        t1 <= a;
        t2 <= b;
        repeat (4) @(posedge clk);
        t1 <= 1'b0;
        t2 <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : pulse
    // ==========
    // scenarios
    initial
    begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rc(`AQS_OFF_STATUS, 32'h1f1f, 32'h0101);
        rc(12'h010, 32'hffffffff, 32'h0);
        chk({31'h0, erv}, 32'h1);
        xfer(1'b1, 12'h300, 32'h1);
        chk({31'h0, erv}, 32'h1);
        for (int i = 0; i < 7; i++)
            xfer(1'b1, 12'h200 + 12'(4 * i), {22'h0, cw[i]});
        xfer(1'b1, `AQS_OFF_Q2CTRL, 32'h0501);
        xfer(1'b1, `AQS_OFF_Q1CTRL, 32'h1);
        xfer(1'b1, `AQS_OFF_Q1CTRL, 32'h5);
        xfer(1'b1, `AQS_OFF_Q2CTRL, 32'h0505);
        rc(`AQS_OFF_STATUS, 32'h1f1f, 32'h1002);
        xfer(1'b1, `AQS_OFF_Q2CTRL, 32'h0505);
        wt(`AQS_OFF_FLAGS, 32'h8, 32'h8);
        rc(`AQS_OFF_FLAGS, 32'h3f, 32'h2a);
        rc(`AQS_OFF_STATUS, 32'h1f1f, 32'h0104);
        xfer(1'b1, `AQS_OFF_FLAGS, 32'h3f);
        xfer(1'b1, `AQS_OFF_Q1CTRL, 32'h5);
        wt(`AQS_OFF_FLAGS, 32'h3, 32'h1);
        rc(`AQS_OFF_Q1CTRL, 32'h1, 32'h0);
        chk(32'(convs), 32'h5);
        for (int i = 0; i < 6; i++)
            if (i != 4)
                rc(12'h300 + 12'(4 * i), 32'h3ff, {22'h0, ex[i]});
        xfer(1'b1, `AQS_OFF_FLAGS, 32'h3f);
        xfer(1'b1, `AQS_OFF_Q1CTRL, 32'h3);
        xfer(1'b1, `AQS_OFF_Q2CTRL, 32'h0501);
        pulse(1'b1, 1'b1);
        rc(`AQS_OFF_STATUS, 32'h1f1f, 32'h1002);
        pulse(1'b1, 1'b1);
        wt(`AQS_OFF_FLAGS, 32'h26, 32'h26);
        // abort queue 2 in its resolution phase
        for (base = 0; base < 400 && !(smp_q === 1'b1 && sample === 1'b0); base++)
            @(posedge clk);
        chk({31'h0, base == 400}, 32'h0);
        if (base == 400)
            stop_test();
        pulse(1'b1, 1'b0);
        rc(`AQS_OFF_STATUS, 32'h1f1f, 32'h0802);
        xfer(1'b1, `AQS_OFF_FLAGS, 32'h3f);
        pulse(1'b0, 1'b1);
        wt(`AQS_OFF_FLAGS, 32'h9, 32'h9);
        rc(`AQS_OFF_FLAGS, 32'h20, 32'h20);
        rc(12'h314, 32'h3ff, 32'h200);
        base = convs;
        pulse(1'b1, 1'b0);
        wt(`AQS_OFF_FLAGS, 32'h2, 32'h2);
        chk(32'(convs - base), 32'h3);
        stop_test();
    end
endmodule : tb_adc_queue_sequencer
`default_nettype wire
